// ===== design/sps_switch_port_status.sv
// Switch port status register bank with control and interrupt registers
`timescale 1ns/1ps

module sps_switch_port_status
  import sps_pkg::*;
#(
  parameter int                ADDR_W       = 8,
  parameter logic [2:0]        CTL_MODE_RST = 3'h0,
  parameter logic [4:0]        CTL_DEV_RST  = 5'h00
)
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]       awaddr,
  input  wire logic                    awvalid,
  output wire logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output wire logic                    wready,
  output wire logic [1:0]              bresp,
  output wire logic                    bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]       araddr,
  input  wire logic                    arvalid,
  output wire logic                    arready,
  output wire logic [31:0]             rdata,
  output wire logic [1:0]              rresp,
  output wire logic                    rvalid,
  input  wire logic                    rready,
  // Mode change and link layer events
  input  wire logic                    mode_change_begin,
  input  wire logic                    mode_change_done,
  input  wire logic                    link_layer_active,
  input  wire logic                    lane_direction,
  // Effective state from partition control
  input  wire logic                    partition_disabled,
  input  wire logic [SPS_MODE_W-1:0]   eff_mode,
  input  wire logic [SPS_PART_W-1:0]   eff_partition_index,
  input  wire logic [SPS_DEVICE_NUMBER_W-1:0] eff_device_number,
  // Programmed control values
  output wire logic [SPS_MODE_W-1:0]   ctl_mode,
  output wire logic [SPS_PART_W-1:0]   ctl_partition_index,
  output wire logic [SPS_DEVICE_NUMBER_W-1:0] ctl_device_number,
  // Interrupt
  output wire logic                    irq
);

  logic                      wr_en;
  logic [ADDR_W-1:0]         wr_addr;
  logic [31:0]               wr_data;
  logic [3:0]                wr_strb;
  logic                      wr_ok;
  logic                      rd_en;
  logic [ADDR_W-1:0]         rd_addr;
  logic [31:0]               rd_data;
  logic                      rd_ok;
  logic                      wr_status;
  logic                      wr_control;
  logic                      wr_mask;
  logic                      rd_irq_stat;
  logic [SPS_FLAG_COUNT-1:0] flag_set;
  logic [SPS_FLAG_COUNT-1:0] flag_clr;
  logic [SPS_FLAG_COUNT-1:0] flag_ff;
  logic                      link_ff;
  logic                      dir_ff;
  logic [SPS_MODE_W-1:0]     mode_ff;
  logic [SPS_PART_W-1:0]     part_ff;
  logic [SPS_DEVICE_NUMBER_W-1:0]   device_number_ff;
  logic [SPS_MODE_W-1:0]     ctl_mode_ff;
  logic [SPS_PART_W-1:0]     ctl_part_ff;
  logic [SPS_DEVICE_NUMBER_W-1:0]   ctl_dev_ff;
  logic [SPS_MODE_W-1:0]     wr_mode;
  logic [SPS_IRQ_W-1:0]      irq_event;
  logic [SPS_IRQ_W-1:0]      irq_stat_ff;
  logic [SPS_IRQ_W-1:0]      irq_mask_ff;
  logic [SPS_IRQ_W-1:0]      nxt_irq_stat;

  // Refuse an address space too small for the four registers
  if (ADDR_W < 4 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("sps_switch_port_status: ADDR_W must be 4 to 32");
  end

  // Word match of a byte address against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a >> 2) == (ADDR_W'(ofs) >> 2);
  endfunction

  // Only the four documented mode codes are accepted
  function automatic logic mode_legal(input logic [SPS_MODE_W-1:0] m);
    case (m)
      SPS_MODE_DISABLED,
      SPS_MODE_DOWNSTREAM,
      SPS_MODE_UPSTREAM,
      SPS_MODE_UNATTACHED: mode_legal = 1'b1;
      default:             mode_legal = 1'b0;
    endcase
  endfunction

  // Bus slave front end
  sps_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Address decode of register accesses
  assign wr_status   = wr_en && hit(wr_addr, SPS_STATUS_OFS);
  assign wr_control  = wr_en && hit(wr_addr, SPS_CONTROL_OFS);
  assign wr_mask     = wr_en && hit(wr_addr, SPS_IRQ_MASK_OFS);
  assign rd_irq_stat = rd_en && hit(rd_addr, SPS_IRQ_STAT_OFS);
  assign wr_ok = hit(wr_addr, SPS_STATUS_OFS) ||
                 hit(wr_addr, SPS_CONTROL_OFS) ||
                 hit(wr_addr, SPS_IRQ_STAT_OFS) ||
                 hit(wr_addr, SPS_IRQ_MASK_OFS);

  // Flag sources; the two spare flags have none
  assign flag_set = {2'b00, mode_change_done, mode_change_begin};

  // Sticky flags, a set in the clearing cycle wins
  for (genvar i = 0; i < SPS_FLAG_COUNT; i++)
  begin : g_flag
    assign flag_clr[i] = wr_status && wr_strb[0] && wr_data[i];
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        flag_ff[i] <= SPS_FLAG_RST[i];
      else if (flag_set[i])
        flag_ff[i] <= 1'b1;
      else if (flag_clr[i])
        flag_ff[i] <= 1'b0;
    end
  end

  // Link state sampled every cycle, lane direction only while the link layer is active
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_ff <= SPS_LINK_RST;
      dir_ff  <= SPS_DIR_RST;
    end
    else
    begin
      link_ff <= link_layer_active;
      if (link_layer_active)
        dir_ff <= lane_direction;
    end
  end

  // Effective mode, partition and device number as now in force
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_ff   <= SPS_MODE_DISABLED;
      part_ff   <= SPS_PART_RST;
      device_number_ff <= SPS_DEVICE_NUMBER_RST;
    end
    else
    begin
      mode_ff   <= partition_disabled ? SPS_MODE_DISABLED
                                      : eff_mode;
      part_ff   <= eff_partition_index;
      device_number_ff <= eff_device_number;
    end
  end

  // Programmed control register, reserved mode codes are dropped
  assign wr_mode = wr_data[SPS_CTL_MODE_LSB +: SPS_MODE_W];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_mode_ff <= CTL_MODE_RST;
      ctl_part_ff <= SPS_PART_RST;
      ctl_dev_ff  <= CTL_DEV_RST;
    end
    else if (wr_control)
    begin
      if (wr_strb[0] && mode_legal(wr_mode))
        ctl_mode_ff <= wr_mode;
      if (wr_strb[0])
        ctl_part_ff <= wr_data[SPS_CTL_PART_LSB +: SPS_PART_W];
      if (wr_strb[1])
        ctl_dev_ff <= wr_data[SPS_CTL_DEVICE_NUMBER_LSB +: SPS_DEVICE_NUMBER_W];
    end
  end

  assign ctl_mode            = ctl_mode_ff;
  assign ctl_partition_index = ctl_part_ff;
  assign ctl_device_number   = ctl_dev_ff;

  // Interrupt events: change begun, change done, link state change
  assign irq_event = {link_layer_active != link_ff,
                      mode_change_done, mode_change_begin};

  // Interrupt status clears on read, a new event still lands
  assign nxt_irq_stat = (rd_irq_stat ? '0 : irq_stat_ff) | irq_event;

  // Interrupt status and mask registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_ff <= SPS_IRQ_RST;
      irq_mask_ff <= SPS_IRQ_RST;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_mask && wr_strb[0])
        irq_mask_ff <= wr_data[SPS_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read data mux, unused bits stay zero
  always_comb
  begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    if (hit(rd_addr, SPS_STATUS_OFS))
    begin
      rd_data[SPS_FLAG_COUNT-1:0]                 = flag_ff;
      rd_data[SPS_LINK_BIT]                       = link_ff;
      rd_data[SPS_DIR_BIT]                        = dir_ff;
      rd_data[SPS_MODE_LSB +: SPS_MODE_W]         = mode_ff;
      rd_data[SPS_PART_LSB +: SPS_PART_W]         = part_ff;
      rd_data[SPS_DEVICE_NUMBER_LSB +: SPS_DEVICE_NUMBER_W]     = device_number_ff;
    end
    else if (hit(rd_addr, SPS_CONTROL_OFS))
    begin
      rd_data[SPS_CTL_MODE_LSB +: SPS_MODE_W]     = ctl_mode_ff;
      rd_data[SPS_CTL_PART_LSB +: SPS_PART_W]     = ctl_part_ff;
      rd_data[SPS_CTL_DEVICE_NUMBER_LSB +: SPS_DEVICE_NUMBER_W] = ctl_dev_ff;
    end
    else if (hit(rd_addr, SPS_IRQ_STAT_OFS))
      rd_data[SPS_IRQ_W-1:0] = irq_stat_ff;
    else if (hit(rd_addr, SPS_IRQ_MASK_OFS))
      rd_data[SPS_IRQ_W-1:0] = irq_mask_ff;
    else
      rd_ok = 1'b0;
  end

  // Checks on the status fields and their causes, and on the programmed mode
  property p_begin_sets;
    @(posedge aclk) disable iff (!aresetn)
    mode_change_begin |=> flag_ff[SPS_FLAG_BEGIN_BIT];
  endproperty
  a_begin_sets: assert property (p_begin_sets)
    else $error("begin flag not set after mode change start");
  property p_begin_clears;
    @(posedge aclk) disable iff (!aresetn)
    (flag_clr[SPS_FLAG_BEGIN_BIT] && !mode_change_begin)
      |=> !flag_ff[SPS_FLAG_BEGIN_BIT];
  endproperty
  a_begin_clears: assert property (p_begin_clears)
    else $error("begin flag not cleared by write of one");
  property p_done_sets;
    @(posedge aclk) disable iff (!aresetn)
    mode_change_done |=> flag_ff[SPS_FLAG_DONE_BIT];
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag not set after mode change end");
  property p_spare_zero;
    @(posedge aclk) disable iff (!aresetn)
    ##1 flag_ff[3:2] == 2'b00;
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("spare flags became set");
  property p_link_follows;
    @(posedge aclk) disable iff (!aresetn)
    $changed(link_layer_active) |=> link_ff == $past(link_layer_active)
      ##0 irq_stat_ff[SPS_IRQ_LINK_BIT];
  endproperty
  a_link_follows: assert property (p_link_follows)
    else $error("link bit or link event wrong after change");
  property p_dir_follows;
    @(posedge aclk) disable iff (!aresetn)
    link_layer_active |=> dir_ff == $past(lane_direction);
  endproperty
  a_dir_follows: assert property (p_dir_follows)
    else $error("lane direction not reported while link up");
  property p_mode_actual;
    @(posedge aclk) disable iff (!aresetn)
    !partition_disabled |=> mode_ff == $past(eff_mode);
  endproperty
  a_mode_actual: assert property (p_mode_actual)
    else $error("reported mode is not the effective mode");
  property p_mode_disabled;
    @(posedge aclk) disable iff (!aresetn)
    partition_disabled |=> mode_ff == SPS_MODE_DISABLED;
  endproperty
  a_mode_disabled: assert property (p_mode_disabled)
    else $error("disabled partition not reported as disabled");
  property p_part_dev;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> part_ff == $past(eff_partition_index) &&
             device_number_ff == $past(eff_device_number);
  endproperty
  a_part_dev: assert property (p_part_dev)
    else $error("partition or device number not the effective one");
  property p_reserved_mode;
    @(posedge aclk) disable iff (!aresetn)
    (wr_control && wr_strb[0] && !mode_legal(wr_mode))
      |=> ctl_mode_ff == $past(ctl_mode_ff);
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved mode code was stored");
  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    (rd_en && hit(rd_addr, SPS_STATUS_OFS)) |=>
      rvalid && rdata[31:21] == 11'h000 && rdata[15:14] == 2'h0 && !rdata[9];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

endmodule

// ===== design/sps_pkg.sv
// Shared constants and types of the switch port status register bank
package sps_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] SPS_STATUS_OFS   = 8'h00;
  localparam logic [7:0] SPS_CONTROL_OFS  = 8'h04;
  localparam logic [7:0] SPS_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] SPS_IRQ_MASK_OFS = 8'h0c;

  // Status register field positions and widths
  localparam int SPS_FLAG_BEGIN_BIT = 0;
  localparam int SPS_FLAG_DONE_BIT  = 1;
  localparam int SPS_FLAG_COUNT     = 4;
  localparam int SPS_LINK_BIT       = 4;
  localparam int SPS_DIR_BIT        = 5;
  localparam int SPS_MODE_LSB       = 6;
  localparam int SPS_MODE_W         = 3;
  localparam int SPS_PART_LSB       = 10;
  localparam int SPS_PART_W         = 4;
  localparam int SPS_DEVICE_NUMBER_LSB     = 16;
  localparam int SPS_DEVICE_NUMBER_W       = 5;

  // Control register field positions
  localparam int SPS_CTL_MODE_LSB   = 0;
  localparam int SPS_CTL_PART_LSB   = 4;
  localparam int SPS_CTL_DEVICE_NUMBER_LSB = 10;

  // Interrupt status and mask bit positions
  localparam int SPS_IRQ_BEGIN_BIT = 0;
  localparam int SPS_IRQ_DONE_BIT  = 1;
  localparam int SPS_IRQ_LINK_BIT  = 2;
  localparam int SPS_IRQ_W         = 3;

  // Port mode codes, shared by programmed and effective mode
  typedef enum logic [2:0] {
    SPS_MODE_DISABLED   = 3'h0,
    SPS_MODE_DOWNSTREAM = 3'h1,
    SPS_MODE_UPSTREAM   = 3'h2,
    SPS_MODE_UNATTACHED = 3'h5
  } sps_mode_type;

  // Reset values
  localparam logic [SPS_FLAG_COUNT-1:0] SPS_FLAG_RST   = 4'h0;
  localparam logic                      SPS_LINK_RST   = 1'h0;
  localparam logic                      SPS_DIR_RST    = 1'h0;
  localparam logic [SPS_PART_W-1:0]     SPS_PART_RST   = 4'h0;
  localparam logic [SPS_DEVICE_NUMBER_W-1:0]   SPS_DEVICE_NUMBER_RST = 5'h00;
  localparam logic [SPS_IRQ_W-1:0]      SPS_IRQ_RST    = 3'h0;

  // Bus response codes
  localparam logic [1:0] SPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;

endpackage

// ===== design/sps_axil_slave.sv
// AXI4-Lite slave front end of the switch port status register bank
`timescale 1ns/1ps
module sps_axil_slave
  import sps_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  // Write response channel
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  // Register side
  output wire logic              wr_en,
  output wire logic [ADDR_W-1:0] wr_addr,
  output wire logic [31:0]       wr_data,
  output wire logic [3:0]        wr_strb,
  input  wire logic              wr_ok,
  output wire logic              rd_en,
  output wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);

  logic              aw_full_ff;
  logic              w_full_ff;
  logic              bvalid_ff;
  logic              rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  // Refuse address widths the decode cannot serve
  if (ADDR_W < 4 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("sps_axil_slave: ADDR_W must be 4 to 32");
  end

  // Channels accept only while no response is pending
  assign awready = !aw_full_ff && !bvalid_ff;
  assign wready  = !w_full_ff && !bvalid_ff;
  assign wr_en   = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = !rvalid_ff;
  assign rd_en   = arvalid && !rvalid_ff;
  assign rd_addr = araddr;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  // Write address holding stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_full_ff <= 1'b1;
      awaddr_ff  <= awaddr;
    end
    else if (wr_en)
      aw_full_ff <= 1'b0;
  end

  // Write data holding stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_ff <= 1'b0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_full_ff <= 1'b1;
      wdata_ff  <= wdata;
      wstrb_ff  <= wstrb;
    end
    else if (wr_en)
      w_full_ff <= 1'b0;
  end

  // Write response, error on an unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= SPS_RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ok ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
    end
    else if (bready)
      bvalid_ff <= 1'b0;
  end

  // Read response, data captured at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= SPS_RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_data;
      rresp_ff  <= rd_ok ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
    end
    else if (rready)
      rvalid_ff <= 1'b0;
  end

endmodule

// ===== verification/tb_switch_port_status_register.sv
// Self-checking bench of the switch port status register bank
`timescale 1ns/1ps
module tb_switch_port_status_register
  import sps_pkg::*;
;
  // Bus and status signals driven by the bench
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic        mc_begin = 1'b0, mc_done = 1'b0, link_up = 1'b0, dir = 1'b0;
  logic        part_dis = 1'b0;
  logic [2:0]  e_mode = 3'h0;
  logic [3:0]  e_part = 4'h0;
  logic [4:0]  e_dev = 5'h00;
  // Outputs of the design
  wire logic        awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  ctl_mode;
  wire logic [3:0]  ctl_part;
  wire logic [4:0]  ctl_dev;
  int          err_count = 0, n_tests = 0, i;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [1:0]  fl = 2'h0;
  logic [2:0]  codes [4] = '{3'h0, 3'h1, 3'h2, 3'h5};

  sps_switch_port_status dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mode_change_begin(mc_begin), .mode_change_done(mc_done),
    .link_layer_active(link_up), .lane_direction(dir),
    .partition_disabled(part_dis), .eff_mode(e_mode),
    .eff_partition_index(e_part), .eff_device_number(e_dev),
    .ctl_mode(ctl_mode), .ctl_partition_index(ctl_part),
    .ctl_device_number(ctl_dev), .irq(irq));

  // Clock of 100 ns period
  always #50 aclk = ~aclk;

  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // A wait that ran out of its bound
  task tmo(input int n);
    if (n >= 50)
    begin
      err_count++;
      finish_test();
    end
  endtask

  // Bus write with both address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50 && !(aw_d && w_d); i++)
    begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_d = 1'b1; wvalid <= 1'b0; end
    end
    tmo(i);
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (bvalid) break;
    end
    tmo(i);
    rsp = bresp;
  endtask

  // Bus read
  task rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready) break;
    end
    tmo(i);
    arvalid <= 1'b0;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (rvalid) break;
    end
    tmo(i);
    rd = rdata;
    rsp = rresp;
  endtask

  // Expected status word from the bench's own drive
  function automatic logic [31:0] sts(input logic [2:0] m);
    return {11'h0, e_dev, 2'h0, e_part, 1'b0, m, dir & link_up, link_up,
            2'h0, fl};
  endfunction

  // Pulse one event input for a cycle
  task pulse(input int which);
    if (which == 0) mc_begin <= 1'b1; else mc_done <= 1'b1;
    @(posedge aclk);
    mc_begin <= 1'b0;
    mc_done <= 1'b0;
    @(posedge aclk);
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values
    rdr(SPS_STATUS_OFS); chk(rd, 32'h0);
    rdr(SPS_CONTROL_OFS); chk(rd, 32'h0);
    rdr(SPS_IRQ_MASK_OFS); chk(rd, 32'h0);
    chk(irq, 1'b0);
    $display("test reset done");
    // Sticky flags and their clearing
    pulse(0); fl = 2'h1;
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    pulse(1); fl = 2'h3;
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    wr(SPS_STATUS_OFS, 32'h1); fl = 2'h2; chk(rsp, SPS_RESP_OKAY);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    wr(SPS_STATUS_OFS, 32'hc);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    wr(SPS_STATUS_OFS, 32'h2); fl = 2'h0;
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    $display("test flags done");
    // Link state and lane direction flip
    link_up <= 1'b1; dir <= 1'b1; e_mode <= SPS_MODE_UNATTACHED;
    repeat (2) @(posedge aclk);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h5));
    dir <= 1'b0;
    repeat (2) @(posedge aclk);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h5));
    $display("test link done");
    // Effective partition index differs from the programmed one; mode and device number match it when k is 2
    wr(SPS_CONTROL_OFS, 32'h0000_3c72);
    for (int k = 0; k < 4; k++)
    begin
      e_mode <= codes[k]; e_part <= 4'(k + 3); e_dev <= 5'(k * 7 + 1);
      repeat (2) @(posedge aclk);
      rdr(SPS_STATUS_OFS);
      chk(rd, sts(codes[k]));
    end
    e_mode <= SPS_MODE_DOWNSTREAM; part_dis <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h0));
    part_dis <= 1'b0;
    $display("test modes done");
    // Programmed mode codes and a reserved code
    for (int k = 0; k < 4; k++)
    begin
      wr(SPS_CONTROL_OFS, {17'h0, 5'(k + 9), 2'h0, 4'(k), 1'b0, codes[k]});
      chk({ctl_dev, ctl_part, ctl_mode},
          {5'(k + 9), 4'(k), codes[k]});
    end
    wr(SPS_CONTROL_OFS, 32'h0000_3033);
    rdr(SPS_CONTROL_OFS); chk(rd[2:0], 3'h5);
    $display("test control done");
    // Writes to read-only fields of status
    wr(SPS_STATUS_OFS, 32'hffff_fff0);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h1));
    $display("test read only done");
    // Interrupt raised, masked and cleared by read
    wr(SPS_IRQ_MASK_OFS, 32'h1);
    rdr(SPS_IRQ_STAT_OFS);
    @(posedge aclk);
    chk(irq, 1'b0);
    pulse(1); fl = 2'h2;
    chk(irq, 1'b0);
    pulse(0); fl = 2'h3;
    chk(irq, 1'b1);
    rdr(SPS_IRQ_STAT_OFS); chk(rd, 32'h3);
    @(posedge aclk);
    chk(irq, 1'b0);
    rdr(SPS_STATUS_OFS); chk(rd, sts(3'h1));
    $display("test interrupt done");
    // Unmapped address
    wr(8'h10, 32'hffff_ffff); chk(rsp, SPS_RESP_SLVERR);
    rdr(8'h10); chk(rd, 32'h0); chk(rsp, SPS_RESP_SLVERR);
    $display("test unmapped done");
    finish_test();
  end
endmodule
